// ---- core/expansion_pause_buffer.sv ----
// Egress buffer that absorbs frame expansion and steers pause requests.
// Assumes the host MAC turns the pause level into 802.3 pause frames.
`timescale 1ns/100ps
module expansion_pause_buffer #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 16,
    parameter int PAUSE_ON = 12,
    parameter int PAUSE_OFF = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady,
    // Flow control toward the system side
    output logic pause
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (1 << PW) != DEPTH || PAUSE_OFF >= PAUSE_ON || PAUSE_ON > DEPTH)
        $error("expansion_pause_buffer: bad depth or thresholds");

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] count;
        logic outValid;
        logic [WIDTH-1:0] outData;
        logic pause;
    } state_t;

    state_t s_q, s_d;
    logic push, pop;

    // Ready reflects stored words only, so a stalled drain really fills it
    assign inReady = s_q.count != CW'(DEPTH);
    assign outValid = s_q.outValid;
    assign outData = s_q.outData;
    assign pause = s_q.pause;

    // Memory, output register and hysteresis on the fill level
    always_comb begin
        s_d = s_q;
        push = inValid && inReady;
        pop = (s_q.count != '0) && (!s_q.outValid || outReady);
        if (push) begin
            s_d.mem[s_q.wr] = inData;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (outReady)
            s_d.outValid = 1'b0;
        if (pop) begin
            s_d.outValid = 1'b1;
            s_d.outData = s_q.mem[s_q.rd];
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.count = s_q.count + CW'(push) - CW'(pop);
        if (s_d.count >= CW'(PAUSE_ON))
            s_d.pause = 1'b1;
        else if (s_d.count <= CW'(PAUSE_OFF))
            s_d.pause = 1'b0;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule // expansion_pause_buffer

// ---- core/macsec_out_pkg.sv ----
// Shared types and constants of the pipeline output stage.
// Assumes one clock domain; the surrounding MACs sit outside this package.
//
// Functional notes
// - Statistics counters in RAM increment per frame as the post-processor instructs.
// - Counter updates yield to software access and overlap the next frame.
// - A skip mask suppresses updates of selected counters.
// - Output adapter isolates pipeline timing from the outbound handshake.
// - Repacker turns 128-bit words into 64-bit words, contents preserved.
// - Frames failing security carry a debug code in the FCS position.
// - Classification fields are chosen separately for every SA entry.
// - Standard mode receive classification uses only DA, SA and SecTAG.
// - Advanced mode may bypass one or two VLAN tags, usable for classification.
// - Advanced mode may bypass EoMPLS header; classify on client addresses, Etype, labels.
// - Both 128-bit and 256-bit key lengths are supported.
// - Egress expansion is absorbed by 802.3 pause toward the system side.
// - Flow-control buffer holds packets and decides pause assert and release.
// - Timestamping sits host side, so timing frames are transformed too.
// - Pipeline sits between host-side MAC and line-side MAC.
// - Dropping a streaming frame sets abort on its last word.
package macsec_out_pkg;

    // Lane geometry; byte 0 of a word sits in bits [7:0]
    localparam int WIDE_W = 128;
    localparam int NARROW_W = 64;
    localparam logic [4:0] HALF_BYTES = 5'h08;
    localparam logic [3:0] NARROW_FULL = 4'h8;
    localparam logic [3:0] DBG_CODE_BYTES = 4'h4;
    localparam int DBG_CODE_W = 32;

    // Classification field select bits
    localparam int FIELD_W = 8;
    localparam int F_DA = 0;
    localparam int F_SA = 1;
    localparam int F_SECTAG = 2;
    localparam int F_VID1 = 3;
    localparam int F_VID2 = 4;
    localparam int F_MPLS_ETYPE = 5;
    localparam int F_LABEL1 = 6;
    localparam int F_LABEL2 = 7;

    // Frame format of an SA entry
    localparam logic [2:0] MODE_STANDARD = 3'h0;
    localparam logic [2:0] MODE_TAG1_BYPASS = 3'h1;
    localparam logic [2:0] MODE_TAG2_BYPASS = 3'h2;
    localparam logic [2:0] MODE_MPLS1_BYPASS = 3'h3;
    localparam logic [2:0] MODE_MPLS2_BYPASS = 3'h4;

    // Default depths and pause thresholds
    localparam int DEF_COUNTERS = 16;
    localparam int DEF_COUNTER_W = 32;
    localparam int DEF_SA_ENTRIES = 16;
    localparam int DEF_BUF_DEPTH = 16;
    localparam int DEF_PAUSE_ON = 12;
    localparam int DEF_PAUSE_OFF = 4;

    typedef struct packed {
        logic [WIDE_W-1:0] data;
        logic sop;
        logic eop;
        logic [4:0] bytes;    // Valid bytes, 1..16, meaningful on eop
        logic abort;          // Drop decision from post-processing
        logic secFail;        // Security check failed
        logic [DBG_CODE_W-1:0] failCode;
    } wide_word_t;

    typedef struct packed {
        logic [NARROW_W-1:0] data;
        logic sop;
        logic eop;
        logic [3:0] bytes;    // Valid bytes, 1..8
        logic abort;
    } narrow_word_t;

    typedef struct packed {
        logic key256;         // 256-bit key instead of 128-bit
        logic [2:0] mode;
        logic [FIELD_W-1:0] fields;
    } sa_cfg_t;

    // Fields visible before decryption for a given format
    function automatic logic [FIELD_W-1:0] rxAllowed(input logic [2:0] mode);
        logic [FIELD_W-1:0] m;
        m = '0;
        m[F_DA] = 1'b1;
        m[F_SA] = 1'b1;
        m[F_SECTAG] = 1'b1;
        case (mode)
            MODE_TAG1_BYPASS: m[F_VID1] = 1'b1;
            MODE_TAG2_BYPASS: begin
                m[F_VID1] = 1'b1;
                m[F_VID2] = 1'b1;
            end
            MODE_MPLS1_BYPASS: begin
                m[F_MPLS_ETYPE] = 1'b1;
                m[F_LABEL1] = 1'b1;
            end
            MODE_MPLS2_BYPASS: begin
                m[F_MPLS_ETYPE] = 1'b1;
                m[F_LABEL1] = 1'b1;
                m[F_LABEL2] = 1'b1;
            end
            default: m = m;
        endcase
        return m;
    endfunction

endpackage

// ---- core/macsec_output_stage.sv ----
// Output stage of the security pipeline: statistics, adapter, repacking,
// per-SA classification select and the expansion pause buffer.
// Assumes post-processing upstream and host/line MAC logic downstream,
// all on one clock; frames arrive without preamble or FCS.
`timescale 1ns/100ps
module macsec_output_stage
    import macsec_out_pkg::*;
#(
    parameter int COUNTERS = DEF_COUNTERS,
    parameter int COUNTER_W = DEF_COUNTER_W,
    parameter int SA_ENTRIES = DEF_SA_ENTRIES,
    parameter int BUF_DEPTH = DEF_BUF_DEPTH,
    parameter int PAUSE_ON = DEF_PAUSE_ON,
    parameter int PAUSE_OFF = DEF_PAUSE_OFF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Wide packet interface from post-processing
    input wire logic inValid,
    input wire wide_word_t inWord,
    output logic inReady,
    // Narrow packet interface toward the MAC
    output logic outValid,
    output narrow_word_t outWord,
    input wire logic outReady,
    // Pause request level toward the system-side MAC
    output logic pauseReq,
    // Statistics instructions and skip configuration
    input wire logic statsValid,
    input wire logic [COUNTERS-1:0] statsMask,
    output logic statsReady,
    input wire logic [COUNTERS-1:0] statsSkip,
    // Software access to the statistics RAM
    input wire logic swReq,
    input wire logic swWrite,
    input wire logic [$clog2(COUNTERS)-1:0] swAddr,
    input wire logic [COUNTER_W-1:0] swWdata,
    output logic swAck,
    output logic [COUNTER_W-1:0] swRdata,
    // Per-SA classification configuration and lookup
    input wire logic saCfgWrite,
    input wire logic [$clog2(SA_ENTRIES)-1:0] saCfgIndex,
    input wire sa_cfg_t saCfgEntry,
    input wire logic saQuery,
    input wire logic [$clog2(SA_ENTRIES)-1:0] saQueryIndex,
    output logic saAnswerValid,
    output logic [FIELD_W-1:0] saTxFields,
    output logic [FIELD_W-1:0] saRxFields,
    output logic saKey256
);
    localparam int AW = $clog2(COUNTERS);

    if (COUNTERS < 2 || (1 << AW) != COUNTERS || SA_ENTRIES < 2 || COUNTER_W < 8)
        $error("macsec_output_stage: unsupported counter or SA geometry");

    typedef enum logic [2:0] {
        PH_LOW = 3'b001,
        PH_HIGH = 3'b010,
        PH_CODE = 3'b100
    } phase_t;

    typedef struct packed {
        logic [COUNTERS-1:0][COUNTER_W-1:0] cnt;
        logic [COUNTERS-1:0] pending;
        logic statsReady;
        logic swAck;
        logic [COUNTER_W-1:0] swRdata;
        logic [SA_ENTRIES-1:0][$bits(sa_cfg_t)-1:0] sa;
        logic saAnswerValid;
        logic [FIELD_W-1:0] saTxFields;
        logic [FIELD_W-1:0] saRxFields;
        logic saKey256;
        logic holdFull;
        wide_word_t hold;
        phase_t phase;
        logic inReady;
    } state_t;

    state_t s_q, s_d;
    narrow_word_t pushWord;
    logic pushValid;
    logic bufReady;
    logic found;
    sa_cfg_t entry;
    logic [4:0] hiBytes;

    // Registered views of the state
    assign inReady = s_q.inReady;
    assign statsReady = s_q.statsReady;
    assign swAck = s_q.swAck;
    assign swRdata = s_q.swRdata;
    assign saAnswerValid = s_q.saAnswerValid;
    assign saTxFields = s_q.saTxFields;
    assign saRxFields = s_q.saRxFields;
    assign saKey256 = s_q.saKey256;

    // All next-state logic of the stage
    always_comb begin
        s_d = s_q;
        pushWord = '0;
        pushValid = 1'b0;
        found = 1'b0;
        entry = '0;
        hiBytes = s_q.hold.bytes - HALF_BYTES;

        // Software access takes the RAM port first; updates wait while swReq is high
        s_d.swAck = swReq;
        if (swReq) begin
            s_d.swRdata = s_q.cnt[swAddr];
            if (swWrite)
                s_d.cnt[swAddr] = swWdata;
        end else begin
            for (int i = 0; i < COUNTERS; i++) begin
                if (s_q.pending[i] && !found) begin
                    found = 1'b1;
                    s_d.cnt[i] = s_q.cnt[i] + 1'b1;
                    s_d.pending[i] = 1'b0;
                end
            end
        end
        // New instruction runs while the next frame is post-processed
        if (statsValid && s_q.statsReady)
            s_d.pending = s_d.pending | (statsMask & ~statsSkip);
        s_d.statsReady = s_d.pending == '0;

        // Per-SA field selection, receive side limited by the format
        if (saCfgWrite)
            s_d.sa[saCfgIndex] = saCfgEntry;
        s_d.saAnswerValid = saQuery;
        if (saQuery) begin
            entry = sa_cfg_t'(s_q.sa[saQueryIndex]);
            s_d.saTxFields = entry.fields;
            s_d.saRxFields = entry.fields & rxAllowed(entry.mode);
            s_d.saKey256 = entry.key256;
        end

        // Adapter: one wide word held, pipeline never sees the MAC handshake
        if (inValid && s_q.inReady) begin
            s_d.hold = inWord;
            s_d.holdFull = 1'b1;
            s_d.phase = PH_LOW;
        end

        // Repacker: low half first, then high half, then the debug code
        if (s_q.holdFull) begin
            pushValid = 1'b1;
            case (s_q.phase)
                PH_LOW: begin
                    pushWord.data = s_q.hold.data[NARROW_W-1:0];
                    pushWord.sop = s_q.hold.sop;
                    if (s_q.hold.eop && s_q.hold.bytes <= HALF_BYTES) begin
                        pushWord.bytes = s_q.hold.bytes[3:0];
                        pushWord.eop = !s_q.hold.secFail;
                        pushWord.abort = s_q.hold.abort && !s_q.hold.secFail;
                    end else begin
                        pushWord.bytes = NARROW_FULL;
                    end
                end
                PH_HIGH: begin
                    pushWord.data = s_q.hold.data[WIDE_W-1:NARROW_W];
                    if (s_q.hold.eop) begin
                        pushWord.bytes = hiBytes[3:0];
                        pushWord.eop = !s_q.hold.secFail;
                        pushWord.abort = s_q.hold.abort && !s_q.hold.secFail;
                    end else begin
                        pushWord.bytes = NARROW_FULL;
                    end
                end
                PH_CODE: begin
                    // Code takes the place of the stripped FCS; frame is dropped
                    pushWord.data = {{(NARROW_W-DBG_CODE_W){1'b0}}, s_q.hold.failCode};
                    pushWord.bytes = DBG_CODE_BYTES;
                    pushWord.eop = 1'b1;
                    pushWord.abort = 1'b1;
                end
                default: pushValid = 1'b0;
            endcase
            if (bufReady) begin
                case (s_q.phase)
                    PH_LOW: begin
                        if (!(s_q.hold.eop && s_q.hold.bytes <= HALF_BYTES))
                            s_d.phase = PH_HIGH;
                        else if (s_q.hold.secFail)
                            s_d.phase = PH_CODE;
                        else
                            s_d.holdFull = 1'b0;
                    end
                    PH_HIGH: begin
                        if (s_q.hold.eop && s_q.hold.secFail)
                            s_d.phase = PH_CODE;
                        else
                            s_d.holdFull = 1'b0;
                    end
                    PH_CODE: s_d.holdFull = 1'b0;
                    default: s_d.phase = PH_LOW;
                endcase
            end
        end
        s_d.inReady = !s_d.holdFull;
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.phase <= PH_LOW;
            s_q.statsReady <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Expansion buffer; its fill level drives the pause request
    expansion_pause_buffer #(
        .WIDTH($bits(narrow_word_t)),
        .DEPTH(BUF_DEPTH),
        .PAUSE_ON(PAUSE_ON),
        .PAUSE_OFF(PAUSE_OFF)
    ) u_pause_buffer (
        .clk(clk),
        .rst_n(rst_n),
        .inValid(pushValid),
        .inData(pushWord),
        .inReady(bufReady),
        .outValid(outValid),
        .outData(outWord),
        .outReady(outReady),
        .pause(pauseReq)
    );
endmodule // macsec_output_stage

// ---- test/mac_sink_model.sv ----
// Line-side MAC stand-in that takes narrow words and records them.
// Assumes the bench sets pace: 0 prompt, 1 every other cycle, 2 stalled.
`timescale 1ns/100ps
module mac_sink_model
    import macsec_out_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Narrow packet interface
    input wire logic outValid,
    input wire narrow_word_t outWord,
    output logic outReady,
    // Pacing from the bench
    input wire logic [1:0] pace
);
    narrow_word_t got[$];
    logic phase;

    // Take on the design's sampling edge; ready only moves after it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outReady <= 1'b0;
            phase <= 1'b0;
        end else begin
            if (outValid && outReady) begin
                got.push_back(outWord);
            end
            phase <= ~phase;
            outReady <= (pace == 2'h0) || (pace == 2'h1 && phase);
        end
    end
endmodule // mac_sink_model

// ---- test/macsec_output_stage_properties.sv ----
// Port-level assertions for the pipeline output stage.
// Assumes it is bound onto macsec_output_stage, one clock domain.
`timescale 1ns/100ps
module macsec_output_stage_properties
    import macsec_out_pkg::*;
#(
    parameter int COUNTERS = DEF_COUNTERS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Packet sides
    input wire logic inValid,
    input wire logic inReady,
    input wire logic outValid,
    input wire narrow_word_t outWord,
    input wire logic outReady,
    // Statistics
    input wire logic statsValid,
    input wire logic [COUNTERS-1:0] statsMask,
    input wire logic statsReady,
    input wire logic [COUNTERS-1:0] statsSkip,
    input wire logic swReq,
    input wire logic swAck,
    // Classification
    input wire logic saQuery,
    input wire logic saAnswerValid,
    input wire logic [FIELD_W-1:0] saTxFields,
    input wire logic [FIELD_W-1:0] saRxFields
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_SW_ACK:
        assert property (swReq |=> swAck) else $error("software access not acknowledged");
    AST_STATS_BUSY:
        assert property (statsValid && statsReady && |(statsMask & ~statsSkip) |=> !statsReady)
        else $error("stats instruction taken without work");
    AST_STATS_DONE:
        assert property ($fell(statsReady) |-> ##[1:40] statsReady)
        else $error("stats update never finished");
    AST_OUT_HOLD:
        assert property (outValid && !outReady |=> outValid && $stable(outWord))
        else $error("narrow word changed while stalled");
    AST_IN_TAKE:
        assert property (inValid && inReady |=> !inReady) else $error("wide word not held");
    AST_OUT_LAT:
        assert property (inValid && inReady && !outValid |-> ##3 outValid)
        else $error("first narrow word late");
    AST_ABORT_EOP:
        assert property (outValid && outWord.abort |-> outWord.eop)
        else $error("abort away from last word");
    AST_EOP_BYTES:
        assert property (outValid && outWord.eop |-> outWord.bytes inside {[4'h1:NARROW_FULL]})
        else $error("bad byte count on last word");
    AST_SA_ANS:
        assert property (saQuery |=> saAnswerValid) else $error("lookup not answered");
    AST_SA_SUBSET:
        assert property (saAnswerValid |-> (saRxFields & ~saTxFields) == '0)
        else $error("rx fields outside configured set");
    AST_SA_EXCL:
        assert property (saAnswerValid |-> !(saRxFields[F_VID1] && saRxFields[F_LABEL1]))
        else $error("tag and label fields mixed");
endmodule // macsec_output_stage_properties

bind macsec_output_stage macsec_output_stage_properties #(.COUNTERS(COUNTERS)) u_props (
    .clk, .rst_n, .inValid, .inReady, .outValid, .outWord, .outReady, .statsValid,
    .statsMask, .statsReady, .statsSkip, .swReq, .swAck, .saQuery, .saAnswerValid,
    .saTxFields, .saRxFields);

// ---- test/tb.sv ----
// Self-checking bench for the output stage with a line-side sink model.
// Assumes small buffer thresholds 4/3/1 and four counters.
`timescale 1ns/100ps
module tb;
    import macsec_out_pkg::*;
    localparam logic [31:0] FC = 32'hC0DE0005;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic inValid = 1'b0;
    wide_word_t inWord = '0;
    logic inReady, outValid, outReady, pauseReq, statsReady, swAck, saAnswerValid, saKey256;
    narrow_word_t outWord;
    logic statsValid = 1'b0;
    logic [3:0] statsMask = '0;
    logic [3:0] statsSkip = '0;
    logic swReq = 1'b0;
    logic swWrite = 1'b0;
    logic [1:0] swAddr = '0;
    logic [31:0] swWdata = '0;
    logic [31:0] swRdata, rd;
    logic saCfgWrite = 1'b0;
    logic saQuery = 1'b0;
    logic [2:0] saCfgIndex = '0;
    logic [2:0] saQueryIndex = '0;
    sa_cfg_t saCfgEntry = '0;
    logic [FIELD_W-1:0] saTxFields, saRxFields;
    logic [1:0] pace = 2'h0;
    narrow_word_t want[$];
    int bad_count = 0;
    int checked = 0;

    always #4 clk = ~clk;

    macsec_output_stage #(.COUNTERS(4), .SA_ENTRIES(8), .BUF_DEPTH(4), .PAUSE_ON(3),
        .PAUSE_OFF(1)) u_macsec_output_stage (.clk, .rst_n, .inValid, .inWord, .inReady,
        .outValid, .outWord, .outReady, .pauseReq, .statsValid, .statsMask, .statsReady,
        .statsSkip, .swReq, .swWrite, .swAddr, .swWdata, .swAck, .swRdata, .saCfgWrite,
        .saCfgIndex, .saCfgEntry, .saQuery, .saQueryIndex, .saAnswerValid, .saTxFields,
        .saRxFields, .saKey256);
    mac_sink_model u_mac_sink_model (.clk, .rst_n, .outValid, .outWord, .outReady, .pace);

    task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One wide word, held until taken; frames carry no FCS
    task automatic send(logic [127:0] d, logic s, logic e, logic [4:0] n, logic a, logic f);
        int k;
        k = 0;
        @(posedge clk);
        inValid <= 1'b1;
        inWord <= '{data: d, sop: s, eop: e, bytes: n, abort: a, secFail: f, failCode: FC};
        do begin
            @(posedge clk);
            k++;
        end while (inReady !== 1'b1 && k < 60);
        inValid <= 1'b0;
        check("wide word taken", k < 60, 1'b1);
    endtask

    task automatic expect_word(logic [63:0] d, logic s, logic e, logic [3:0] n, logic a);
        want.push_back('{data: d, sop: s, eop: e, bytes: n, abort: a});
    endtask

    // Byte counts only mean something on the last word
    task automatic drain();
        int k;
        narrow_word_t g;
        for (k = 0; k < 200 && u_mac_sink_model.got.size() < want.size(); k++) @(posedge clk);
        check("word count", u_mac_sink_model.got.size(), want.size());
        foreach (want[i]) begin
            g = u_mac_sink_model.got[i];
            check("narrow word", {g.data, g.sop, g.eop, g.abort},
                {want[i].data, want[i].sop, want[i].eop, want[i].abort});
            if (want[i].eop) check("last bytes", g.bytes, want[i].bytes);
        end
        want.delete();
        u_mac_sink_model.got.delete();
    endtask

    task automatic sw(logic wr, logic [1:0] a, logic [31:0] wd, output logic [31:0] r);
        @(posedge clk);
        swReq <= 1'b1;
        swWrite <= wr;
        swAddr <= a;
        swWdata <= wd;
        @(posedge clk);
        swReq <= 1'b0;
        @(posedge clk);
        check("swAck", swAck, 1'b1);
        r = swRdata;
    endtask

    task automatic stats(logic [3:0] m);
        int k;
        k = 0;
        @(posedge clk);
        statsValid <= 1'b1;
        statsMask <= m;
        do @(posedge clk); while (statsReady !== 1'b1);
        statsValid <= 1'b0;
        @(posedge clk);
        while (statsReady !== 1'b1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        check("stats done", k < 40, 1'b1);
    endtask

    task automatic t_reset();
        // Registered ready only shows after the first edge out of reset
        repeat (2) @(posedge clk);
        check("inReady", inReady, 1'b1);
        check("statsReady", statsReady, 1'b1);
        check("pauseReq", pauseReq, 1'b0);
    endtask

    // Two-word frame through a slow sink, low half first
    task automatic t_split();
        pace <= 2'h1;
        send(128'h00112233445566778899AABBCCDDEEFF, 1'b1, 1'b0, 5'h10, 1'b0, 1'b0);
        send(128'h00000000111122223333444455556666, 1'b0, 1'b1, 5'h0C, 1'b0, 1'b0);
        expect_word(64'h8899AABBCCDDEEFF, 1'b1, 1'b0, 4'h8, 1'b0);
        expect_word(64'h0011223344556677, 1'b0, 1'b0, 4'h8, 1'b0);
        expect_word(64'h3333444455556666, 1'b0, 1'b0, 4'h8, 1'b0);
        expect_word(64'h0000000011112222, 1'b0, 1'b1, 4'h4, 1'b0);
        drain();
        pace <= 2'h0;
    endtask

    // Dropped short frame, then two security failures, each with its debug word
    task automatic t_drop();
        send(128'h0000000000000000000000AABBCCDDEE, 1'b1, 1'b1, 5'h05, 1'b1, 1'b0);
        expect_word(64'h000000AABBCCDDEE, 1'b1, 1'b1, 4'h5, 1'b1);
        send(128'hFFEEDDCCBBAA99887766554433221100, 1'b1, 1'b1, 5'h10, 1'b0, 1'b1);
        expect_word(64'h7766554433221100, 1'b1, 1'b0, 4'h8, 1'b0);
        expect_word(64'hFFEEDDCCBBAA9988, 1'b0, 1'b0, 4'h8, 1'b0);
        expect_word({32'h0, FC}, 1'b0, 1'b1, DBG_CODE_BYTES, 1'b1);
        send(128'h00000000000000000000000000112233, 1'b1, 1'b1, 5'h03, 1'b0, 1'b1);
        expect_word(64'h0000000000112233, 1'b1, 1'b0, 4'h3, 1'b0);
        expect_word({32'h0, FC}, 1'b0, 1'b1, DBG_CODE_BYTES, 1'b1);
        drain();
    endtask

    // Skipped counter stays put, software access overlaps, counters wrap
    task automatic t_stats();
        statsSkip <= 4'h4;
        fork
            stats(4'h7);
            sw(1'b0, 2'h3, 32'h0, rd);
        join
        sw(1'b0, 2'h0, 32'h0, rd);
        check("counter0", rd, 32'h1);
        sw(1'b0, 2'h2, 32'h0, rd);
        check("counter2", rd, 32'h0);
        sw(1'b1, 2'h1, 32'hFFFFFFFF, rd);
        stats(4'h2);
        sw(1'b0, 2'h1, 32'h0, rd);
        check("counter1", rd, 32'h0);
    endtask

    // One entry per frame format, SA field left out of the selection
    task automatic t_sa();
        logic [7:0] rx[5] = '{8'h05, 8'h0D, 8'h1D, 8'h65, 8'hE5};
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            saCfgWrite <= 1'b1;
            saCfgIndex <= 3'(i);
            saCfgEntry <= '{key256: i[0], mode: 3'(i), fields: 8'hFD};
        end
        @(posedge clk);
        saCfgWrite <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            saQuery <= 1'b1;
            saQueryIndex <= 3'(i);
            @(posedge clk);
            saQuery <= 1'b0;
            @(posedge clk);
            check("saAnswerValid", saAnswerValid, 1'b1);
            check("saTxFields", saTxFields, 8'hFD);
            check("saRxFields", saRxFields, rx[i]);
            check("saKey256", saKey256, i[0]);
        end
    endtask

    // Stalled sink fills the buffer up to the pause threshold
    task automatic t_pause();
        int k;
        pace <= 2'h2;
        send(128'h0F0E0D0C0B0A09080706050403020100, 1'b1, 1'b0, 5'h10, 1'b0, 1'b0);
        send(128'h1F1E1D1C1B1A19181716151413121110, 1'b0, 1'b1, 5'h10, 1'b0, 1'b0);
        for (k = 0; k < 20 && pauseReq !== 1'b1; k++) @(posedge clk);
        check("pause raised", pauseReq, 1'b1);
        pace <= 2'h0;
        expect_word(64'h0706050403020100, 1'b1, 1'b0, 4'h8, 1'b0);
        expect_word(64'h0F0E0D0C0B0A0908, 1'b0, 1'b0, 4'h8, 1'b0);
        expect_word(64'h1716151413121110, 1'b0, 1'b0, 4'h8, 1'b0);
        expect_word(64'h1F1E1D1C1B1A1918, 1'b0, 1'b1, 4'h8, 1'b0);
        drain();
        repeat (2) @(posedge clk);
        check("pause released", pauseReq, 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_split();
        t_drop();
        t_stats();
        t_sa();
        t_pause();
        final_report();
    end

    // Hang guard, well beyond the hundred or so cycles the tests need
    initial begin
        #400000;
        bad_count++;
        final_report();
    end
endmodule // tb
